// ---- design/asci_pkg.sv ----
package asci_pkg;
    // Frame length in serial clock cycles.
    localparam logic [4:0] FRAME_BITS = 5'h10;
    // Rising edge count at which the sampler returns to track.
    localparam logic [4:0] TRACK_EDGE = 5'h0e;
    // Rising edge count at which the control register commits.
    localparam logic [4:0] CTRL_COMMIT_EDGE = 5'h0f;
    // Falling edge count at which sequence or range registers commit.
    localparam logic [4:0] SEQ_COMMIT_EDGE = 5'h0b;
    // Received word layout, most significant bit first.
    localparam int WRITE_BIT = 15;
    localparam int SEL_MSB = 14;
    localparam int SEL_LSB = 12;
    // Register select codes.
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_RANGE1 = 3'h1;
    localparam logic [2:0] SEL_RANGE2 = 3'h2;
    localparam logic [2:0] SEL_SEQ = 3'h3;
    // Reset values of the on-chip registers.
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [10:0] WORD11_RESET = 11'h000;
    // Leading bit of every result frame.
    localparam logic LEAD_BIT = 1'b0;
endpackage

// ---- design/asci_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// Two-flop level synchroniser; the first stage feeds only the second.
module asci_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] stage1;

    ////////////////////////////////////////////////////////////////////////
    // Both stages reset to zero.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage1 <= '0;
            q_o <= '0;
        end else begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- design/asci_shift_out.sv ----
`timescale 1ns/1ns
`default_nettype none
// Result shifter on the falling serial clock edge.
module asci_shift_out (
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [15:0] word_i,
    output logic sdo_o
);
    logic [3:0] idx;

    ////////////////////////////////////////////////////////////////////////
    // Chip select high clears the index, so bit 15 (the leading zero) is on
    // the line the moment chip select falls; each falling edge steps on.
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            idx <= 4'h0;
        end else if (idx != 4'hf) begin
            idx <= idx + 4'h1;
        end
    end

    assign sdo_o = word_i[4'hf - idx];
endmodule
`default_nettype wire

// ---- design/asci_core.sv ----
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Chip select falling puts sampler in hold and enables serial output.
// - A frame is exactly 16 serial clock cycles after chip select falls.
// - Sampler returns to track on the 14th rising serial clock edge.
// - Serial output floats on the 16th falling serial clock edge.
// - Early chip select rise aborts conversion and floats output.
// - Input bits are captured on falling serial clock edges; control bit 0 is taken from the line on the 15th rising edge.
// - The three input bits after the leading write bit select the target register.
// - The control register is twelve bits wide.
// - Control register commits on the 15th rising edge.
// - Sequence and range registers commit on the 11th falling edge.
// - Output moves to the next result bit on each falling edge.
// - Frame is zero, two channel bits, sign, twelve result bits.
// - Leading zero driven at chip select fall, channel bit after first fall.
// - Registers are written only when the write bit is set.
//
// The serial clock is the link domain. Register contents and the sampler
// state cross into the system clock domain through two-flop synchronisers.
// Link registers only change while chip select is low, so the register
// outputs are refreshed only while the synchronised select is high; a host
// that idles with chip select low sees new settings after its next release.
module asci_core (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic [1:0] conv_channel_i,
    input wire logic conv_sign_i,
    input wire logic [11:0] conv_result_i,
    output logic hold_o,
    output logic [11:0] ctrl_reg_o,
    output logic [10:0] range1_reg_o,
    output logic [10:0] range2_reg_o,
    output logic [10:0] seq_reg_o,
    output logic frame_done_o
);
    ////////////////////////////////////////////////////////////////////////
    // Link domain state.
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [15:0] rx_shift;
    logic [15:0] tx_word;
    logic sample_hold;
    logic oe_off;
    logic [11:0] ctrl_q;
    logic [10:0] range1_q;
    logic [10:0] range2_q;
    logic [10:0] seq_q;
    logic done_tgl;
    logic [15:0] rx_next;
    logic [2:0] sel_early;
    logic seq_fire;
    logic ctrl_fire;
    logic sdo_raw;

    // Input word with the current bit appended, for commits on a fall.
    assign rx_next = {rx_shift[14:0], sdi_i};
    // Select bits of a word that has shifted in eleven bits so far.
    assign sel_early = rx_next[asci_pkg::SEL_MSB - 5:asci_pkg::SEL_LSB - 5];
    // The write bit leads the word and sits ten places up after eleven bits.
    assign seq_fire = (fall_cnt == asci_pkg::SEQ_COMMIT_EDGE - 5'h1)
                      && rx_next[asci_pkg::WRITE_BIT - 5]
                      && (sel_early != asci_pkg::SEL_CTRL);
    // Fifteen bits are in by the fifteenth rising edge; the last bit is taken
    // from the line, so the host must present it before that rising edge.
    assign ctrl_fire = (rise_cnt == asci_pkg::CTRL_COMMIT_EDGE - 5'h1)
                       && rx_shift[asci_pkg::WRITE_BIT - 1]
                       && (rx_shift[asci_pkg::SEL_MSB - 1:asci_pkg::SEL_LSB - 1]
                           == asci_pkg::SEL_CTRL);
    // Hold runs from the chip select fall until the track edge is counted.
    assign sample_hold = !cs_n_i && (rise_cnt < asci_pkg::TRACK_EDGE);

    ////////////////////////////////////////////////////////////////////////
    // Falling-edge side: input capture, output timing and late registers.
    // Chip select high acts as the frame reset, which also covers an early
    // abort: counts clear, so no late commit can occur.
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fall_cnt <= 5'h00;
            rx_shift <= 16'h0000;
            oe_off <= 1'b0;
        end else begin
            rx_shift <= rx_next;
            if (fall_cnt != asci_pkg::FRAME_BITS) begin
                fall_cnt <= fall_cnt + 5'h01;
            end
            if (fall_cnt == asci_pkg::FRAME_BITS - 5'h1) begin
                oe_off <= 1'b1;
            end
        end
    end

    // Sequence and range registers survive chip select, so only nrst_i clears them.
    always_ff @(negedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            range1_q <= asci_pkg::WORD11_RESET;
            range2_q <= asci_pkg::WORD11_RESET;
            seq_q <= asci_pkg::WORD11_RESET;
        end else if (!cs_n_i && seq_fire) begin
            if (sel_early == asci_pkg::SEL_RANGE1) begin
                range1_q <= rx_next[10:0];
            end else if (sel_early == asci_pkg::SEL_RANGE2) begin
                range2_q <= rx_next[10:0];
            end else if (sel_early == asci_pkg::SEL_SEQ) begin
                seq_q <= rx_next[10:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rising-edge side: sampler state and the control register.
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rise_cnt <= 5'h00;
        end else if (rise_cnt != asci_pkg::FRAME_BITS) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // Control register keeps its value across frames; twelve bits wide.
    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= asci_pkg::CTRL_RESET;
            done_tgl <= 1'b0;
        end else if (!cs_n_i) begin
            if (ctrl_fire) begin
                ctrl_q <= {rx_shift[10:0], sdi_i};
            end
            if (rise_cnt == asci_pkg::FRAME_BITS - 5'h1) begin
                done_tgl <= ~done_tgl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result word, most significant first: zero, channel, sign, result.
    assign tx_word = {asci_pkg::LEAD_BIT, conv_channel_i, conv_sign_i,
                      conv_result_i};

    asci_shift_out u_shift (
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .word_i(tx_word),
        .sdo_o(sdo_raw)
    );

    // Pins are combinational off chip select by nature: the output turns on
    // asynchronously at the chip select fall, before any serial clock edge.
    assign sdo_o = sdo_raw;
    assign sdo_oe_o = !cs_n_i && !oe_off;

    ////////////////////////////////////////////////////////////////////////
    // Crossing into the system clock domain.
    logic cs_low_s;
    logic hold_s;
    logic [11:0] ctrl_s;
    logic [10:0] r1_s;
    logic [10:0] r2_s;
    logic [10:0] seq_s;
    logic done_s;
    logic done_d;

    asci_sync #(.WIDTH(3)) u_sync_ctl (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .d_i({!cs_n_i, sample_hold, done_tgl}),
        .q_o({cs_low_s, hold_s, done_s})
    );

    asci_sync #(.WIDTH(45)) u_sync_regs (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .d_i({ctrl_q, range1_q, range2_q, seq_q}),
        .q_o({ctrl_s, r1_s, r2_s, seq_s})
    );

    // Hold is reported from chip select fall until the track edge.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_o <= 1'b0;
            ctrl_reg_o <= asci_pkg::CTRL_RESET;
            range1_reg_o <= asci_pkg::WORD11_RESET;
            range2_reg_o <= asci_pkg::WORD11_RESET;
            seq_reg_o <= asci_pkg::WORD11_RESET;
            done_d <= 1'b0;
            frame_done_o <= 1'b0;
        end else begin
            hold_o <= hold_s;
            // Registers are static while deselected, so no word is torn here.
            if (!cs_low_s) begin
                ctrl_reg_o <= ctrl_s;
                range1_reg_o <= r1_s;
                range2_reg_o <= r2_s;
                seq_reg_o <= seq_s;
            end
            done_d <= done_s;
            frame_done_o <= done_s ^ done_d;
        end
    end
endmodule
`default_nettype wire

// ---- test/asci_core_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// Watches the serial pins of the converter core against the frame timing.
module asci_core_asserts (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic [1:0] conv_channel_i,
    input wire logic conv_sign_i,
    input wire logic [11:0] conv_result_i,
    input wire logic hold_o,
    input wire logic [11:0] ctrl_reg_o,
    input wire logic [10:0] range1_reg_o,
    input wire logic [10:0] range2_reg_o,
    input wire logic [10:0] seq_reg_o,
    input wire logic frame_done_o
);
    logic [4:0] f;
    logic [4:0] r;
    wire logic [15:0] fw = {asci_pkg::LEAD_BIT, conv_channel_i, conv_sign_i, conv_result_i};
    // Edge counts of the current frame; they saturate so an idle low select cannot wrap.
    always_ff @(negedge sclk_i or posedge cs_n_i or negedge nrst_i) begin
        if (!nrst_i || cs_n_i) f <= 5'h00;
        else if (f != 5'h1f) f <= f + 5'h01;
    end
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge nrst_i) begin
        if (!nrst_i || cs_n_i) r <= 5'h00;
        else if (r != 5'h1f) r <= r + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////////
    a_oe_in_frame: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !cs_n_i && f < 5'h10 |-> sdo_oe_o) else $error("output floats in frame");
    a_oe_off_end: assert property (@(posedge clock_i) disable iff (!nrst_i)
        f == 5'h10 |-> !sdo_oe_o) else $error("output driven after frame");
    a_oe_idle_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
        cs_n_i |-> !sdo_oe_o) else $error("output driven while deselected");
    a_lead_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !cs_n_i && f == 5'h00 |-> sdo_oe_o && !sdo_o) else $error("leading bit wrong");
    a_frame_bits: assert property (@(posedge sclk_i) disable iff (!nrst_i)
        !cs_n_i && f inside {[1:15]} |-> sdo_o == fw[5'h0f - f]) else $error("frame bit wrong");
    a_hold_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $fell(cs_n_i) |-> ##[1:4] hold_o) else $error("no hold after select");
    a_track_at14: assert property (@(posedge clock_i) disable iff (!nrst_i)
        r == 5'h0e |-> ##[1:4] !hold_o) else $error("no track after edge 14");
    a_done_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
        frame_done_o |=> !frame_done_o) else $error("done longer than one cycle");
    a_regs_quiet: assert property (@(posedge clock_i) disable iff (!nrst_i)
        cs_n_i [*8] |-> $stable(ctrl_reg_o) && $stable(seq_reg_o) && $stable(range1_reg_o)
        && $stable(range2_reg_o)) else $error("register moved while idle");
    // Main scenarios: a full frame, a commit point and an early abort.
    c_done: cover property (@(posedge clock_i) frame_done_o);
    c_commit: cover property (@(posedge sclk_i) f == 5'h0b);
    c_abort: cover property (@(posedge clock_i) $rose(cs_n_i) && f > 5'h00 && f < 5'h10);
endmodule
bind asci_core asci_core_asserts u_asci_core_asserts (.clock_i, .nrst_i, .sclk_i, .cs_n_i,
    .sdi_i, .sdo_o, .sdo_oe_o, .conv_channel_i, .conv_sign_i, .conv_result_i, .hold_o,
    .ctrl_reg_o, .range1_reg_o, .range2_reg_o, .seq_reg_o, .frame_done_o);
`default_nettype wire

// ---- test/asci_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host serial port: clock parks high, data is scrambled between frames.
module asci_host_model (
    input wire logic go_i,
    input wire logic [15:0] word_i,
    input wire logic [4:0] ncyc_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    output logic busy_o,
    output logic [15:0] rx_o
);
    // A floating output must never read as a held bit.
    wire logic line = sdo_oe_i ? sdo_i : ~sdo_i;
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        busy_o = 1'b0;
        rx_o = 16'h0000;
    end
    // One word per select; fixed 15 ns halves keep starts on whole periods.
    always @(posedge go_i) begin
        busy_o = 1'b1;
        #7 cs_n_o = 1'b0;
        sdi_o = word_i[15];
        // Data moves in the low phase, clear of both edges, and the answer is
        // taken just before the falling edge that would replace it.
        for (int i = 1; i <= ncyc_i; i++) begin
            #15 rx_o = {rx_o[14:0], line};
            sclk_o = 1'b0;
            #7 sdi_o = (i < 16) ? word_i[15 - i] : ~sdi_o;
            #8 sclk_o = 1'b1;
        end
        #15 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #60 busy_o = 1'b0;
    end
endmodule
`default_nettype wire

// ---- test/adc_serial_conversion_interface_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", nm, e, s); end end
module adc_serial_conversion_interface_tb;
    logic clk, nrst, sclk, cs_n, sdi, sdo, oe, sgn, hold, done, go, busy;
    logic [1:0] ch;
    logic [11:0] res, ctrl, e_ctrl;
    logic [10:0] r1, r2, sq;
    logic [10:0] e_w [1:3];
    logic [15:0] word, rx;
    logic [4:0] ncyc;
    logic [4:0] cuts [4] = '{5'h0f, 5'h0e, 5'h0b, 5'h0a};
    int failures, n_compared;
    asci_core u_asci_core (.clock_i(clk), .nrst_i(nrst), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .conv_channel_i(ch), .conv_sign_i(sgn),
        .conv_result_i(res), .hold_o(hold), .ctrl_reg_o(ctrl), .range1_reg_o(r1),
        .range2_reg_o(r2), .seq_reg_o(sq), .frame_done_o(done));
    asci_host_model u_asci_host_model (.go_i(go), .word_i(word), .ncyc_i(ncyc), .sdo_i(sdo),
        .sdo_oe_i(oe), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .busy_o(busy), .rx_o(rx));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One frame with fresh conversion data; a cut frame is checked on the bits it got.
    task automatic frame(input logic [15:0] w, input logic [4:0] n);
        logic [15:0] f;
        int t, nd;
        nd = 0;
        @(posedge clk);
        ch <= 2'($urandom);
        sgn <= 1'($urandom);
        res <= 12'($urandom);
        word <= w;
        ncyc <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        f = {asci_pkg::LEAD_BIT, ch, sgn, res};
        for (t = 0; busy === 1'b1 && t < 200; t++) begin
            @(posedge clk);
            nd += int'(done === 1'b1);
        end
        if (t == 200) begin
            failures++;
            give_verdict();
        end
        repeat (6) begin
            @(posedge clk);
            nd += int'(done === 1'b1);
        end
        `CHK("done", int'(n == 5'h10), nd)
        if (w[15] && w[14:12] == asci_pkg::SEL_CTRL && n >= asci_pkg::CTRL_COMMIT_EDGE)
            e_ctrl = w[11:0];
        if (w[15] && w[14] == 1'b0 && w[13:12] != 2'h0 && n >= asci_pkg::SEQ_COMMIT_EDGE)
            e_w[w[13:12]] = w[15:5];
        `CHK("frame", f >> (16 - n), rx & (16'hffff >> (16 - n)))
        `CHK("oe", 1'b0, oe)
        if (n >= 5'h0e) `CHK("hold", 1'b0, hold)
        `CHK("ctrl", e_ctrl, ctrl)
        `CHK("range1", e_w[1], r1)
        `CHK("range2", e_w[2], r2)
        `CHK("seq", e_w[3], sq)
    endtask
    // Every select code, a cleared write bit, cuts around each commit edge, then random.
    initial begin
        nrst = 1'b0;
        go = 1'b0;
        word = 16'h0000;
        ncyc = 5'h10;
        ch = 2'h0;
        sgn = 1'b0;
        res = 12'h000;
        failures = 0;
        n_compared = 0;
        e_ctrl = asci_pkg::CTRL_RESET;
        e_w = '{default: asci_pkg::WORD11_RESET};
        void'($urandom(64));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        `CHK("ctrl_rst", asci_pkg::CTRL_RESET, ctrl)
        for (int s = 0; s < 4; s++) frame({1'b1, 3'(s), 12'($urandom)}, 5'h10);
        frame({1'b0, asci_pkg::SEL_CTRL, 12'hfff}, 5'h10);
        $display("test selects done");
        for (int i = 0; i < 8; i++)
            frame({1'b1, i[0] ? asci_pkg::SEL_SEQ : asci_pkg::SEL_CTRL, 12'($urandom)},
                cuts[i / 2]);
        $display("test aborts done");
        repeat (20) frame({1'b1, 3'($urandom_range(3)), 12'($urandom)},
            5'($urandom_range(16, 3)));
        $display("test random done");
        give_verdict();
    end
endmodule
`default_nettype wire
